// *** rtl/rtccal_defs.vh ***
// Purpose: constants for the timebase trim and clock output block
// Assumes: aclk at 100 MHz, osc_in is the 32.768 kHz timebase clock
// Notes: byte addresses are four times the register index
`ifndef RTCCAL_DEFS_VH
`define RTCCAL_DEFS_VH
`define RTCCAL_IDX_CTRL 4'h7
`define RTCCAL_IDX_TRIM 4'h8
`define RTCCAL_IDX_STAT 4'h9
`define RTCCAL_ADDR_CTRL 6'h1c
`define RTCCAL_ADDR_TRIM 6'h20
`define RTCCAL_ADDR_STAT 6'h24
`define RTCCAL_CTRL_RESET 8'h00
`define RTCCAL_TRIM_RESET 8'h00
`define RTCCAL_BIT_OUT 7
`define RTCCAL_BIT_SQUARE_WAVE_ENABLE 6
`define RTCCAL_BIT_RS2 2
`define RTCCAL_TRIM_SIGN 7
`define RTCCAL_SEC_CYC 16'h8000
`define RTCCAL_HALF_SEC 16'h4000
`define RTCCAL_P4096 16'h0008
`define RTCCAL_P8192 16'h0004
`define RTCCAL_HALF64 16'h0100
`define RTCCAL_SEC_PER_MIN 6'h3b
`define RTCCAL_RESP_OKAY 2'h0
`define RTCCAL_RESP_SLVERR 2'h2
`endif

// *** rtl/rtccal_top.v ***
// Purpose: per-minute timebase trim and divided clock on the
//    multi-function pin, registers over AXI4-Lite
// Assumes: osc_in, on_backup and main_ok are asynchronous pins
// Notes: the timebase advances on each rising osc_in edge seen in aclk
// Function
// [R01] trim timebase once per minute
// [R02] sign bit one removes, zero inserts
// [R03] adjust by twice the magnitude
// [R04] square_wave_enable and rate bits drive the pin
// [R05] backup supply disables divided clock
// [R06] periods 32768, 8, 4, 1 cycles
// [R07] code 11 passes undivided, untrimmed clock
// [R08] trim 00h or 80h means none
// [R09] 1 Hz: only minute period changes
// [R10] duty cycle may be unequal
// [R11] codes 01/10 insert: stall output
// [R12] codes 01/10 remove: within short period
// [R13] rs2 set: 512-cycle 64 Hz clock
// [R14] 64 Hz: every period trimmed
// [R15] out bit drives pin as level
// [R16] backup: only alarm level kept
// [R17] refuse access while main supply low
// [R18] counters keep running during test clock
`include "rtccal_defs.vh"
module rtccal_top (
   input wire aclk,
   input wire aresetn,
   input wire [5:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [5:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire osc_in,
   input wire on_backup,
   input wire main_ok,
   input wire alarm_level,
   output reg multi_function_pin_oe,
   output reg multi_function_pin_o,
   output reg minute_tick
);
   reg [2:0] osc_sync;
   reg [1:0] bk_sync;
   reg [1:0] ok_sync;
   reg [7:0] ctrl;
   reg [7:0] trim;
   reg [15:0] sec_cnt;
   reg [5:0] sec_in_min;
   reg [7:0] pend;
   reg [15:0] div_cnt;
   reg [15:0] cal64_cnt;
   reg divided_clock_output;
   reg cal64;
   reg aw_hold;
   reg w_hold;
   reg [5:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   wire tick;
   wire trim_on;
   wire [7:0] trim_cyc;
   wire last_sec;
   wire roll;
   wire trim_now;
   wire backup;
   wire access_ok;
   wire [1:0] rs_lo;
   wire [15:0] sec_len;
   wire [15:0] half64;
   reg [15:0] per_len;
   reg next_pin;
   wire do_write;

   // seven-bit magnitudes x2, in cycles
   function [7:0] twice;
      input [7:0] t;
      begin
         twice = {t[6:0], 1'b0};
      end
   endfunction

   // register index decode, shared by both channels
   function [1:0] reg_sel;
      input [5:0] a;
      begin
         if (a == `RTCCAL_ADDR_CTRL)
            reg_sel = 2'h1;
         else if (a == `RTCCAL_ADDR_TRIM)
            reg_sel = 2'h2;
         else if (a == `RTCCAL_ADDR_STAT)
            reg_sel = 2'h3;
         else
            reg_sel = 2'h0;
      end
   endfunction

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         osc_sync <= 3'h0;
         bk_sync <= 2'h0;
         ok_sync <= 2'h0;
      end
      else
      begin
         osc_sync <= {osc_sync[1:0], osc_in};
         bk_sync <= {bk_sync[0], on_backup};
         ok_sync <= {ok_sync[0], main_ok};
      end
   end

   // osc_sync[0] feeds only osc_sync[1]
   assign tick = osc_sync[1] & ~osc_sync[2];
   assign backup = bk_sync[1];
   assign access_ok = ok_sync[1] & ~backup;
   assign trim_on = trim[6:0] != 7'h00; // [R08]
   assign trim_cyc = twice(trim); // [R03]
   assign last_sec = sec_in_min == `RTCCAL_SEC_PER_MIN;
   assign roll = sec_cnt >= sec_len - 16'h0001;
   // the registered minute pulse never meets a tick, so decode here
   assign trim_now = last_sec && roll && trim_on; // [R01]
   assign rs_lo = ctrl[1:0];
   // minute second length: 32768 +/- 2*mag
   assign sec_len = (last_sec && trim_on) ?
      (trim[`RTCCAL_TRIM_SIGN] ? // [R02]
       `RTCCAL_SEC_CYC - {8'h00, trim_cyc} :
       `RTCCAL_SEC_CYC + {8'h00, trim_cyc}) :
      `RTCCAL_SEC_CYC; // [R01] [R09]
   // 64 Hz half period: 256 +/- 2*mag, every cycle
   assign half64 = !trim_on ? `RTCCAL_HALF64 :
      (trim[`RTCCAL_TRIM_SIGN] ?
       `RTCCAL_HALF64 - {8'h00, trim_cyc} :
       `RTCCAL_HALF64 + {8'h00, trim_cyc}); // [R14]

   // timebase: seconds and minute counting never pause
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sec_cnt <= 16'h0000;
         sec_in_min <= 6'h00;
         minute_tick <= 1'b0;
      end
      else
      begin
         minute_tick <= 1'b0;
         if (tick) // [R18]
         begin
            if (roll)
            begin
               sec_cnt <= 16'h0000;
               if (last_sec)
               begin
                  sec_in_min <= 6'h00;
                  minute_tick <= 1'b1; // [R01]
               end
               else
                  sec_in_min <= sec_in_min + 6'h01;
            end
            else
               sec_cnt <= sec_cnt + 16'h0001;
         end
      end
   end

   always @*
   begin
      case (rs_lo)
         2'h1: per_len = `RTCCAL_P4096;
         2'h2: per_len = `RTCCAL_P8192;
         default: per_len = `RTCCAL_SEC_CYC;
      endcase
   end

   // fast divided clocks: trim once a minute, insert stalls
   // the waveform, removal is cut short at one period
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         div_cnt <= 16'h0000;
         pend <= 8'h00;
         divided_clock_output <= 1'b0;
      end
      else if (tick)
      begin
         if (rs_lo == 2'h0)
         begin
            // 1 Hz follows the trimmed second directly
            pend <= 8'h00;
            div_cnt <= 16'h0000;
            divided_clock_output <= sec_cnt < `RTCCAL_HALF_SEC; // [R09] [R10]
         end
         else if (trim_now && !trim[`RTCCAL_TRIM_SIGN])
            // this tick is the first stalled one
            pend <= trim_cyc - 8'h01; // [R11]
         else if (pend != 8'h00)
            pend <= pend - 8'h01; // [R11]
         else
         begin
            if (trim_now)
            begin
               // removal: skip to period end, remainder dropped
               div_cnt <= 16'h0000;
               divided_clock_output <= 1'b0; // [R12] [R10]
            end
            else if (div_cnt >= per_len - 16'h0001)
            begin
               div_cnt <= 16'h0000;
               divided_clock_output <= 1'b0;
            end
            else
            begin
               div_cnt <= div_cnt + 16'h0001;
               divided_clock_output <= div_cnt + 16'h0001 >= (per_len >> 1); // [R06]
            end
         end
      end
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cal64_cnt <= 16'h0000;
         cal64 <= 1'b0;
      end
      else if (tick)
      begin
         if (cal64_cnt >= half64 - 16'h0001)
         begin
            cal64_cnt <= 16'h0000;
            cal64 <= ~cal64; // [R13]
         end
         else
            cal64_cnt <= cal64_cnt + 16'h0001;
      end
   end

   // pin select; undivided clock uses the synced osc, untrimmed
   always @*
   begin
      if (backup)
         next_pin = alarm_level; // [R05] [R16]
      else if (!ctrl[`RTCCAL_BIT_SQUARE_WAVE_ENABLE])
         next_pin = ctrl[`RTCCAL_BIT_OUT]; // [R15]
      else if (ctrl[`RTCCAL_BIT_RS2])
         next_pin = cal64; // [R13]
      else if (rs_lo == 2'h3)
         next_pin = osc_sync[2]; // [R07]
      else
         next_pin = divided_clock_output; // [R04]
   end

   // open drain: drive only low
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         multi_function_pin_o <= 1'b0;
         multi_function_pin_oe <= 1'b0;
      end
      else
      begin
         multi_function_pin_o <= 1'b0;
         multi_function_pin_oe <= ~next_pin;
      end
   end

   // write channel: address and data in either order
   assign do_write = aw_hold && w_hold && !s_axi_bvalid;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RTCCAL_RESP_OKAY;
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_addr <= 6'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         ctrl <= `RTCCAL_CTRL_RESET;
         trim <= `RTCCAL_TRIM_RESET;
      end
      else
      begin
         s_axi_awready <= !aw_hold && !s_axi_awready;
         s_axi_wready <= !w_hold && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write)
         begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (!access_ok)
               s_axi_bresp <= `RTCCAL_RESP_SLVERR; // [R17]
            else
            begin
               case (reg_sel(aw_addr))
                  2'h1:
                  begin
                     s_axi_bresp <= `RTCCAL_RESP_OKAY;
                     if (w_strb[0])
                        ctrl <= w_data[7:0]; // [R04]
                  end
                  2'h2:
                  begin
                     s_axi_bresp <= `RTCCAL_RESP_OKAY;
                     if (w_strb[0])
                        trim <= w_data[7:0]; // [R01]
                  end
                  2'h3: s_axi_bresp <= `RTCCAL_RESP_OKAY;
                  default: s_axi_bresp <= `RTCCAL_RESP_SLVERR;
               endcase
            end
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // read channel: one read at a time
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RTCCAL_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RTCCAL_RESP_OKAY;
            if (!access_ok)
               s_axi_rresp <= `RTCCAL_RESP_SLVERR; // [R17]
            else
            begin
               case (reg_sel(s_axi_araddr))
                  2'h1: s_axi_rdata <= {24'h000000, ctrl};
                  2'h2: s_axi_rdata <= {24'h000000, trim};
                  2'h3: s_axi_rdata <= {24'h000000, backup,
                     trim_on, sec_in_min};
                  default: s_axi_rresp <= `RTCCAL_RESP_SLVERR;
               endcase
            end
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
endmodule // rtccal_top

// *** tb/rtccal_asserts.sv ***
// Purpose: port-level checks for rtccal_top
// Assumes: one aclk domain, synchronous active-low reset
// Notes: bound onto every rtccal_top instance
`include "rtccal_defs.vh"
module rtccal_asserts (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire on_backup,
   input wire main_ok,
   input wire alarm_level,
   input wire multi_function_pin_oe,
   input wire multi_function_pin_o,
   input wire minute_tick
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_pin_open_drain: assert property (
      multi_function_pin_o == 1'b0) else $error("pin driven high");
   chk_backup_alarm: assert property (
      on_backup && $past(on_backup, 2) && $past(on_backup, 4)
      && $past(aresetn, 4) && $stable(alarm_level)
      |=> multi_function_pin_oe == !$past(alarm_level))
      else $error("pin not following alarm in backup");
   chk_resp_taken: assert property (
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("bvalid kept after bready");
   chk_rdata_taken: assert property (
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("rvalid kept after rready");
   chk_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   // the supply flag reaches the bus logic through two flops
   chk_read_refused: assert property (
      s_axi_arvalid && s_axi_arready && !$past(main_ok, 2)
      |=> s_axi_rresp == `RTCCAL_RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("read allowed at low supply");
   chk_write_refused: assert property (
      $rose(s_axi_bvalid) && !$past(main_ok, 3)
      |-> s_axi_bresp == `RTCCAL_RESP_SLVERR)
      else $error("write allowed at low supply");
   chk_upper_zero: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits set");
   chk_tick_pulse: assert property (
      minute_tick |=> !minute_tick)
      else $error("minute tick longer than one cycle");
endmodule // rtccal_asserts
bind rtccal_top rtccal_asserts i_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .on_backup(on_backup),
   .main_ok(main_ok), .alarm_level(alarm_level),
   .multi_function_pin_oe(multi_function_pin_oe),
   .multi_function_pin_o(multi_function_pin_o),
   .minute_tick(minute_tick));

// *** tb/rtccal_pin_mon.sv ***
// Purpose: observer of the multi-function pin
// Assumes: pin already resolved with its pull-up
// Notes: period is falling edge to falling edge
module rtccal_pin_mon (
   input wire pin,
   output int edges,
   output time period
);
   timeunit 1ns;
   timeprecision 1ns;
   time last = 0;
   initial edges = 0;
   initial period = 0;
   always @(negedge pin)
   begin
      period = $time - last;
      last = $time;
      edges++;
   end
endmodule // rtccal_pin_mon

// *** tb/testbench.sv ***
// Purpose: self-checking bench for rtccal_top
// Assumes: osc_in period of 6 aclk cycles, 60 ns
// Notes: minute-based trims are too long to reach here
`include "rtccal_defs.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0;
   logic arv = 0, rry = 0, osc = 0, bk = 0, mok = 1, alm = 0;
   logic [5:0] awa = 0, ara = 0;
   logic [31:0] wd = 0;
   wire awr, wrd, brv, arr, rv, oe, po, tick;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire pin = oe ? po : 1'b1;
   int mismatches = 0, tests_run = 0, edges;
   time period;
   int osc_div = 0;
   rtccal_top i_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(brv),
      .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rv), .s_axi_rready(rry), .osc_in(osc),
      .on_backup(bk), .main_ok(mok), .alarm_level(alm),
      .multi_function_pin_oe(oe), .multi_function_pin_o(po),
      .minute_tick(tick));
   rtccal_pin_mon i_mon (.pin(pin), .edges(edges), .period(period));
   initial forever #5 aclk = ~aclk;
   // 60 ns timebase clock, three aclk cycles per half period
   always @(posedge aclk)
   begin
      osc_div <= (osc_div == 2) ? 0 : osc_div + 1;
      if (osc_div == 2)
         osc <= ~osc;
   end
   task conclude;
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e)
      begin
         mismatches++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task tmo;
      mismatches++;
      $display("mismatch at %0t: wait ran out", $time);
      conclude;
   endtask
   task wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] e);
      int n;
      n = 0;
      awa <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      bry <= 1;
      do
      begin
         @(posedge aclk);
         if (awr) awv <= 0;
         if (wrd) wv <= 0;
         if (++n > 99) tmo;
      end while (brv !== 1'b1);
      bry <= 0;
      chk({30'h0, bresp}, {30'h0, e});
      // idle edge: bready must not fall and rise in one step
      @(posedge aclk);
   endtask
   task rd(input logic [5:0] a, input logic [31:0] x, input logic [1:0] e);
      int n;
      n = 0;
      ara <= a;
      arv <= 1;
      rry <= 1;
      do
      begin
         @(posedge aclk);
         if (arr) arv <= 0;
         if (++n > 99) tmo;
      end while (rv !== 1'b1);
      rry <= 0;
      chk(rdata, x);
      chk({30'h0, rresp}, {30'h0, e});
      @(posedge aclk);
   endtask
   task pin_is(input logic e);
      repeat (8) @(posedge aclk);
      chk({31'h0, pin}, {31'h0, e});
   endtask
   // last of three periods after the write, so a mode change never skews it
   task rate(input logic [7:0] ct, input logic [7:0] tr, input int x);
      int n, e0;
      n = 0;
      wr(`RTCCAL_ADDR_TRIM, {24'h0, tr}, `RTCCAL_RESP_OKAY);
      wr(`RTCCAL_ADDR_CTRL, {24'h0, ct}, `RTCCAL_RESP_OKAY);
      e0 = edges;
      while (edges < e0 + 3)
      begin
         @(posedge aclk);
         if (++n > 12000) tmo;
      end
      chk(32'(period / 60), x);
   endtask
   task t_regs;
      // control resets to 00, so the level bit pulls the pin low
      pin_is(0);
      rd(`RTCCAL_ADDR_CTRL, 32'h0, `RTCCAL_RESP_OKAY);
      rd(`RTCCAL_ADDR_TRIM, 32'h0, `RTCCAL_RESP_OKAY);
      wr(6'h3c, 32'h5, `RTCCAL_RESP_SLVERR);
      rd(6'h3c, 32'h0, `RTCCAL_RESP_SLVERR);
      wr(`RTCCAL_ADDR_TRIM, 32'ha5, `RTCCAL_RESP_OKAY);
      rd(`RTCCAL_ADDR_TRIM, 32'ha5, `RTCCAL_RESP_OKAY);
      rd(`RTCCAL_ADDR_STAT, 32'h40, `RTCCAL_RESP_OKAY);
      wr(`RTCCAL_ADDR_TRIM, 32'h80, `RTCCAL_RESP_OKAY);
      rd(`RTCCAL_ADDR_STAT, 32'h00, `RTCCAL_RESP_OKAY);
      wr(`RTCCAL_ADDR_CTRL, 32'h80, `RTCCAL_RESP_OKAY);
      pin_is(1);
      wr(`RTCCAL_ADDR_CTRL, 32'h00, `RTCCAL_RESP_OKAY);
      pin_is(0);
   endtask
   task t_rates;
      // the run ends long before the first half second is out
      wr(`RTCCAL_ADDR_CTRL, 32'h40, `RTCCAL_RESP_OKAY);
      pin_is(1);
      rate(8'h41, 8'h7f, 8);
      rate(8'h42, 8'h7f, 4);
      rate(8'h43, 8'h7f, 1);
      rate(8'h44, 8'h03, 2 * (256 + 2 * 3));
      rate(8'h47, 8'h83, 2 * (256 - 2 * 3));
      rate(8'h44, 8'h80, 2 * 256);
   endtask
   task t_backup;
      int e0;
      wr(`RTCCAL_ADDR_CTRL, 32'h43, `RTCCAL_RESP_OKAY);
      bk <= 1;
      pin_is(0);
      alm <= 1;
      e0 = edges;
      pin_is(1);
      repeat (40) @(posedge aclk);
      chk(edges, e0);
      rd(`RTCCAL_ADDR_TRIM, 32'h0, `RTCCAL_RESP_SLVERR);
      bk <= 0;
      // the backup flag needs the synchroniser's edges to clear
      repeat (4) @(posedge aclk);
   endtask
   task t_supply;
      wr(`RTCCAL_ADDR_TRIM, 32'h11, `RTCCAL_RESP_OKAY);
      mok <= 0;
      repeat (6) @(posedge aclk);
      wr(`RTCCAL_ADDR_TRIM, 32'h22, `RTCCAL_RESP_SLVERR);
      rd(`RTCCAL_ADDR_TRIM, 32'h0, `RTCCAL_RESP_SLVERR);
      mok <= 1;
      repeat (6) @(posedge aclk);
      rd(`RTCCAL_ADDR_TRIM, 32'h11, `RTCCAL_RESP_OKAY);
   endtask
   initial
   begin
      repeat (4) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      t_regs;
      t_rates;
      t_backup;
      t_supply;
      conclude;
   end
endmodule // testbench
